// ### design/ospt_pkg.sv
// constants for the oscillator select and crystal to pll translation block
// assumes a 32-bit avalon-mm slave with byte addresses
package ospt_pkg;

    // register byte offsets
    localparam logic [7:0] OSPT_RUN_MODE_CLOCK_CONFIG_OFS = 8'h60;
    localparam logic [7:0] OSPT_CRYSTAL_TO_PLL_TRANSLATION_OFS = 8'h64;

    // run_mode_clock_config field positions
    localparam int OSPT_CRYSTAL_SELECT_LSB = 6;
    localparam int OSPT_CRYSTAL_SELECT_W = 4;
    localparam int OSPT_SRC_LSB = 4;
    localparam int OSPT_SRC_W = 2;
    localparam int OSPT_INTERNAL_OSCILLATOR_DIS_BIT = 1;
    localparam int OSPT_MOSC_DIS_BIT = 0;

    // run_mode_clock_config reset values
    localparam logic [3:0] OSPT_CRYSTAL_SELECT_RST = 4'hB;
    localparam logic [1:0] OSPT_SRC_RST = 2'h1;
    localparam logic OSPT_INTERNAL_OSCILLATOR_DIS_RST = 1'b0;
    localparam logic OSPT_MOSC_DIS_RST = 1'b1;

    // crystal_to_pll_translation field positions
    localparam int OSPT_F_LSB = 5;
    localparam int OSPT_F_W = 9;
    localparam int OSPT_R_LSB = 0;
    localparam int OSPT_R_W = 5;

    // lowest crystal code usable with the pll
    localparam logic [3:0] OSPT_CRYSTAL_SELECT_PLL_MIN = 4'h4;

    // oscillator source encodings
    typedef enum logic [1:0] {
        OSPT_SRC_MAIN = 2'h0,
        OSPT_SRC_INT = 2'h1,
        OSPT_SRC_INT_DIV4 = 2'h2,
        OSPT_SRC_INT_30K = 2'h3
    } ospt_src_t;

endpackage

// ### design/ospt_crystal_select_lut.sv
// crystal code to pll feedback and reference divider lookup
// assumes vco = crystal * (f + 1) / (r + 1), nominal 400 mhz
`timescale 1ns/1ps
module ospt_crystal_select_lut (
    input wire logic [3:0] crystal_select_i,
    output logic [8:0] fb_o,
    output logic [4:0] ref_o
);

    // codes below the pll minimum have no valid setting, give zero
    always_comb begin
        fb_o = 9'h000;
        ref_o = 5'h00;
        unique case (crystal_select_i)
            4'h4: begin fb_o = 9'h1BE; ref_o = 5'h03; end // 3.579545 mhz, x447/4
            4'h5: begin fb_o = 9'h1B1; ref_o = 5'h03; end // 3.6864 mhz, x434/4
            4'h6: begin fb_o = 9'h18F; ref_o = 5'h03; end // 4 mhz, x400/4
            4'h7: begin fb_o = 9'h186; ref_o = 5'h03; end // 4.096 mhz, x391/4
            4'h8: begin fb_o = 9'h196; ref_o = 5'h04; end // 4.9152 mhz, x407/5
            4'h9: begin fb_o = 9'h18F; ref_o = 5'h04; end // 5 mhz, x400/5
            4'hA: begin fb_o = 9'h186; ref_o = 5'h04; end // 5.12 mhz, x391/5
            4'hB: begin fb_o = 9'h18F; ref_o = 5'h05; end // 6 mhz, x400/6
            4'hC: begin fb_o = 9'h186; ref_o = 5'h05; end // 6.144 mhz, x391/6
            4'hD: begin fb_o = 9'h1B1; ref_o = 5'h07; end // 7.3728 mhz, x434/8
            4'hE: begin fb_o = 9'h18F; ref_o = 5'h07; end // 8 mhz, x400/8
            4'hF: begin fb_o = 9'h186; ref_o = 5'h07; end // 8.192 mhz, x391/8
            default: begin fb_o = 9'h000; ref_o = 5'h00; end
        endcase
    end

endmodule // ospt_crystal_select_lut

// ### design/ospt_avmm_slave.sv
// avalon-mm handshake: one wait cycle, then the access completes
// assumes the master holds read or write until waitrequest is low
`timescale 1ns/1ps
module ospt_avmm_slave (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    output logic avs_waitrequest_o,
    output logic first_o,
    output logic done_o
);

    typedef struct packed {
        logic ack;
    } ospt_slv_state_t;

    ospt_slv_state_t s_q;
    ospt_slv_state_t s_d;
    logic req;

    // first cycle prepares read data, second cycle completes
    always_comb begin
        req = avs_read_i | avs_write_i;
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        avs_waitrequest_o = req & ~s_q.ack;
        first_o = req & ~s_q.ack;
        done_o = req & s_q.ack;
    end

    // ack state
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // ospt_avmm_slave

// ### design/ospt_osc_select.sv
// oscillator source select, oscillator enables and crystal to pll translation
// assumes avalon-mm master on sys_clk_i; analog pll and oscillators read the outputs
`timescale 1ns/1ps
// What this block does
// [R1] two-bit source field picks main, internal, internal/4 or 30 khz; resets internal
// [R2] software picks internal/4, not plain internal, when the internal oscillator feeds pll
// [R3] internal oscillator disable bit 1 resets 0; 1 stops the oscillator
// [R4] main oscillator disable bit 0 resets 1; 0 enables, 1 disables
// [R5] translation register is loaded at reset and is read only
// [R6] translation is recomputed whenever the crystal field changes
// [R7] translation bits 13:5 hold the feedback multiplier driven to the pll
// [R8] translation bits 4:0 hold the reference divider; bits 31:14 read zero
// [R9] crystal field bits 9:6 resets 0xB; only codes 0x4 up are pll-valid
// [R10] feedback and reference come from a fixed table indexed by crystal code
module ospt_osc_select (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] clock_source_select_o,
    output logic internal_osc_enable_o,
    output logic main_osc_enable_o,
    output logic [8:0] pll_feedback_mult_o,
    output logic [4:0] pll_ref_div_o,
    output logic crystal_pll_valid_o
);

    typedef struct packed {
        logic [3:0] crystal_select;
        logic [1:0] src;
        logic internal_oscillator_dis;
        logic mosc_dis;
        logic [8:0] fb;
        logic [4:0] rdiv;
        logic [3:0] crystal_select_seen;
        logic [31:0] rdata;
    } ospt_state_t;

    localparam logic [8:0] FB_RST = 9'h18F; // table entry for crystal code 0xB
    localparam logic [4:0] RDIV_RST = 5'h05;

    ospt_state_t s_q;
    ospt_state_t s_d;
    logic first;
    logic done;
    logic [8:0] lut_fb;
    logic [4:0] lut_rdiv;
    logic [31:0] cfg_word;
    logic [31:0] pll_word;
    logic [31:0] be_mask;
    logic [31:0] wr_word;

    ospt_avmm_slave u_slave (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_waitrequest_o(avs_waitrequest_o),
        .first_o(first),
        .done_o(done)
    );

    // fixed table, nominal vco for every supported crystal
    ospt_crystal_select_lut u_lut (
        .crystal_select_i(s_q.crystal_select),
        .fb_o(lut_fb),
        .ref_o(lut_rdiv)
    ); // [R10]

    // next state: register writes, translation update, read data capture
    always_comb begin
        s_d = s_q;
        // register images, unlisted bits read zero
        cfg_word = '0;
        cfg_word[ospt_pkg::OSPT_CRYSTAL_SELECT_LSB +: ospt_pkg::OSPT_CRYSTAL_SELECT_W] = s_q.crystal_select; // [R9]
        cfg_word[ospt_pkg::OSPT_SRC_LSB +: ospt_pkg::OSPT_SRC_W] = s_q.src; // [R1]
        cfg_word[ospt_pkg::OSPT_INTERNAL_OSCILLATOR_DIS_BIT] = s_q.internal_oscillator_dis; // [R3]
        cfg_word[ospt_pkg::OSPT_MOSC_DIS_BIT] = s_q.mosc_dis; // [R4]
        pll_word = '0; // upper bits stay zero [R8]
        pll_word[ospt_pkg::OSPT_F_LSB +: ospt_pkg::OSPT_F_W] = s_q.fb; // [R7]
        pll_word[ospt_pkg::OSPT_R_LSB +: ospt_pkg::OSPT_R_W] = s_q.rdiv; // [R8]
        // byte enables merge new data into the old image
        be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        wr_word = (cfg_word & ~be_mask) | (avs_writedata_i & be_mask);
        // read data captured in the wait cycle, stands while waitrequest is low
        if (first && avs_read_i) begin
            if (avs_address_i == ospt_pkg::OSPT_RUN_MODE_CLOCK_CONFIG_OFS) begin
                s_d.rdata = cfg_word;
            end else if (avs_address_i == ospt_pkg::OSPT_CRYSTAL_TO_PLL_TRANSLATION_OFS) begin
                s_d.rdata = pll_word;
            end else begin
                s_d.rdata = '0; // unmapped reads return zero
            end
        end
        // writes land at the completing edge; translation writes are dropped [R5]
        if (done && avs_write_i && avs_address_i == ospt_pkg::OSPT_RUN_MODE_CLOCK_CONFIG_OFS) begin
            s_d.crystal_select = wr_word[ospt_pkg::OSPT_CRYSTAL_SELECT_LSB +: ospt_pkg::OSPT_CRYSTAL_SELECT_W]; // [R9]
            s_d.src = wr_word[ospt_pkg::OSPT_SRC_LSB +: ospt_pkg::OSPT_SRC_W]; // [R1]
            s_d.internal_oscillator_dis = wr_word[ospt_pkg::OSPT_INTERNAL_OSCILLATOR_DIS_BIT]; // [R3]
            s_d.mosc_dis = wr_word[ospt_pkg::OSPT_MOSC_DIS_BIT]; // [R4]
        end
        // crystal change reloads translation one cycle after the write
        if (s_q.crystal_select != s_q.crystal_select_seen) begin
            s_d.fb = lut_fb; // [R6]
            s_d.rdiv = lut_rdiv; // [R6]
            s_d.crystal_select_seen = s_q.crystal_select;
        end
    end

    // state register; reset loads translation for the reset crystal code
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q.crystal_select <= ospt_pkg::OSPT_CRYSTAL_SELECT_RST; // [R9]
            s_q.src <= ospt_pkg::OSPT_SRC_RST; // [R1]
            s_q.internal_oscillator_dis <= ospt_pkg::OSPT_INTERNAL_OSCILLATOR_DIS_RST; // [R3]
            s_q.mosc_dis <= ospt_pkg::OSPT_MOSC_DIS_RST; // [R4]
            s_q.fb <= FB_RST; // [R5]
            s_q.rdiv <= RDIV_RST; // [R5]
            s_q.crystal_select_seen <= ospt_pkg::OSPT_CRYSTAL_SELECT_RST;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs to bus, oscillators and pll
    assign avs_readdata_o = s_q.rdata;
    assign clock_source_select_o = s_q.src; // [R1]
    assign internal_osc_enable_o = ~s_q.internal_oscillator_dis; // [R3]
    assign main_osc_enable_o = ~s_q.mosc_dis; // [R4]
    assign pll_feedback_mult_o = s_q.fb; // [R7]
    assign pll_ref_div_o = s_q.rdiv; // [R8]
    // software must still pick internal/4 itself when the pll uses it
    assign crystal_pll_valid_o = (s_q.crystal_select >= ospt_pkg::OSPT_CRYSTAL_SELECT_PLL_MIN); // [R9]

endmodule // ospt_osc_select

// ### tb/ospt_ana_model.sv
// behavioural model of the oscillators and pll fed by the block
// assumes it only watches the block's clock-control outputs
`timescale 1ns/1ps
module ospt_ana_model (
    input wire logic [1:0] src_i,
    input wire logic int_en_i,
    input wire logic main_en_i,
    output logic src_live_o,
    output logic pll_src_ok_o
);
    // the chosen source only ticks while its oscillator is on
    always_comb begin
        src_live_o = (src_i == ospt_pkg::OSPT_SRC_MAIN) ? main_en_i : int_en_i;
        pll_src_ok_o = src_i != ospt_pkg::OSPT_SRC_INT; // undivided internal is too fast for the pll
    end
endmodule // ospt_ana_model

// ### tb/ospt_chk.sv
// assertions on the osc select block's bus and clock-control ports
// assumes one clock domain and a bind onto the top module
`timescale 1ns/1ps
module ospt_chk (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] clock_source_select_o,
    input wire logic internal_osc_enable_o,
    input wire logic main_osc_enable_o,
    input wire logic [8:0] pll_feedback_mult_o,
    input wire logic [4:0] pll_ref_div_o,
    input wire logic crystal_pll_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [31:0] wd_q;
    // completed accesses as the master sees them
    wire wr_ok = avs_write_i && !avs_waitrequest_o;
    wire rd_ok = avs_read_i && !avs_waitrequest_o;
    wire cfg = avs_address_i == ospt_pkg::OSPT_RUN_MODE_CLOCK_CONFIG_OFS;
    wire trn = avs_address_i == ospt_pkg::OSPT_CRYSTAL_TO_PLL_TRANSLATION_OFS;
    // write data one cycle late, for the output checks
    always_ff @(posedge sys_clk_i) wd_q <= avs_writedata_i;
    a_wait_one: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("wait cycle count wrong");
    a_src_write: assert property (wr_ok && cfg && avs_byteenable_i[0] |=> clock_source_select_o == wd_q[5:4])
        else $error("source select not updated");
    a_main_en: assert property (wr_ok && cfg && avs_byteenable_i[0] |=> main_osc_enable_o == !wd_q[0])
        else $error("main oscillator enable wrong");
    a_int_en: assert property (wr_ok && cfg && avs_byteenable_i[0] |=> internal_osc_enable_o == !wd_q[1])
        else $error("internal oscillator enable wrong");
    a_cfg_stable: assert property (!wr_ok |=> $stable({clock_source_select_o, internal_osc_enable_o, main_osc_enable_o}))
        else $error("clock outputs moved without a write");
    a_cfg_read: assert property (rd_ok && cfg |-> crystal_pll_valid_o == (avs_readdata_o[9:6] >= 4'h4)
        && avs_readdata_o[5:0] == {clock_source_select_o, 2'h0, !internal_osc_enable_o, !main_osc_enable_o})
        else $error("config read disagrees with outputs");
    a_trans_read: assert property (rd_ok && trn && !$past(avs_write_i, 2)
        |-> avs_readdata_o == {18'h0, pll_feedback_mult_o, pll_ref_div_o})
        else $error("translation read disagrees with pll outputs");
    a_trans_hold: assert property (!wr_ok ##1 !wr_ok |=> $stable({pll_feedback_mult_o, pll_ref_div_o}))
        else $error("pll values moved without a write");
    c_cfg_wr: cover property (wr_ok && cfg);
    c_trn_rd: cover property (rd_ok && trn);
    c_trn_wr: cover property (wr_ok && trn);
endmodule // ospt_chk
bind ospt_osc_select ospt_chk u_chk (.sys_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .clock_source_select_o,
    .internal_osc_enable_o, .main_osc_enable_o, .pll_feedback_mult_o, .pll_ref_div_o, .crystal_pll_valid_o);

// ### tb/tb_top.sv
// self-checking bench for the osc select block over avalon-mm
// assumes the block ends each access by dropping waitrequest
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CFG = ospt_pkg::OSPT_RUN_MODE_CLOCK_CONFIG_OFS;
    localparam logic [7:0] TRN = ospt_pkg::OSPT_CRYSTAL_TO_PLL_TRANSLATION_OFS;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdata;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic avs_waitrequest_o, internal_osc_enable_o, main_osc_enable_o, crystal_pll_valid_o, live, pok;
    logic [1:0] clock_source_select_o;
    logic [8:0] pll_feedback_mult_o;
    logic [4:0] pll_ref_div_o;
    int n_fail = 0, checks_done = 0;
    // expected {feedback, reference} per crystal code
    logic [13:0] lut [16] = '{14'h0, 14'h0, 14'h0, 14'h0, 14'h37C3, 14'h3623, 14'h31E3, 14'h30C3,
        14'h32C4, 14'h31E4, 14'h30C4, 14'h31E5, 14'h30C5, 14'h3627, 14'h31E7, 14'h30C7};
    ospt_osc_select uut (.sys_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .clock_source_select_o, .internal_osc_enable_o,
        .main_osc_enable_o, .pll_feedback_mult_o, .pll_ref_div_o, .crystal_pll_valid_o);
    ospt_ana_model u_model (.src_i(clock_source_select_o), .int_en_i(internal_osc_enable_o),
        .main_en_i(main_osc_enable_o), .src_live_o(live), .pll_src_ok_o(pok));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one access, held until waitrequest is seen low; a hang counts as a mismatch
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= b;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            final_report();
        end
    endtask
    // reset, then every documented reset value at pins and registers
    task automatic reset_chk();
        rstn_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        chk({clock_source_select_o, internal_osc_enable_o, main_osc_enable_o}, 4'h6);
        bus(1'b0, CFG, 32'h0, 4'h0); chk(rdata, 32'h2D1);
        bus(1'b0, TRN, 32'h0, 4'h0); chk(rdata, 32'h31E5);
    endtask
    initial begin
        reset_chk();
        // every crystal code and source, reserved bits written as ones
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, CFG, {22'h3FFFFF, k[3:0], k[1:0], 2'h3, k[2], k[3]}, 4'hF);
            repeat (2) @(posedge sys_clk_i);
            bus(1'b0, CFG, 32'h0, 4'h0); chk(rdata, {22'h0, k[3:0], k[1:0], 2'h0, k[2], k[3]});
            bus(1'b0, TRN, 32'h0, 4'h0); chk(rdata, lut[k]);
            chk({clock_source_select_o, !internal_osc_enable_o, !main_osc_enable_o,
                pll_feedback_mult_o, pll_ref_div_o, crystal_pll_valid_o},
                {k[1:0], k[2], k[3], lut[k], k[3:0] >= 4'h4});
            chk({live, pok}, {(k[1:0] == 0) ? !k[3] : !k[2], k[1:0] != 1});
        end
        bus(1'b1, TRN, 32'hFFFFFFFF, 4'hF);
        repeat (3) @(posedge sys_clk_i);
        bus(1'b0, TRN, 32'h0, 4'h0); chk(rdata, lut[15]);
        // lane 1 only: crystal drops from 0xF to 0x3, lane 0 kept
        bus(1'b1, CFG, 32'h0, 4'h2);
        repeat (2) @(posedge sys_clk_i);
        bus(1'b0, CFG, 32'h0, 4'h0); chk(rdata, 32'h0F3);
        bus(1'b0, TRN, 32'h0, 4'h0); chk(rdata, 32'h0);
        bus(1'b0, 8'h10, 32'h0, 4'h0);
        chk(rdata, 32'h0);
        reset_chk();
        final_report();
    end
endmodule // tb_top
